// [rtl/lcd_bridge_pkg.sv]
package lcd_bridge_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [15:0] display_window_first = 16'h1800;
    localparam logic [15:0] display_window_last = 16'h1fff;
    localparam logic [15:0] expansion_window_first = 16'h2800;
    localparam logic [15:0] expansion_window_last = 16'h2fff;
    localparam logic [15:0] primary_display_write_port = 16'h1800;
    localparam logic [15:0] secondary_display_write_port = 16'h1802;
    localparam logic [1:0] upper_select_clear = 2'h0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int addr_top_hi_bit = 15;
    localparam int addr_top_lo_bit = 14;
    localparam int addr_display_enable_bit = 2;
    localparam int addr_display_choice_bit = 1;
    localparam int addr_expansion_bit = 0;
    localparam int data_expansion_bit = 0;

    // ------------------------------------------------------------
    // reset values and fixed levels
    // ------------------------------------------------------------
    localparam logic [7:0] held_data_reset = 8'h00;
    localparam logic select_idle_level = 1'b1;
    localparam logic display_write_level = 1'b0;
    localparam logic key_column_idle_level = 1'b1;
    localparam logic present_absent_level = 1'b1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic phase;
        logic read;
        logic [15:0] addr;
        logic [7:0] data;
    } bus_in_type;

    typedef struct packed {
        logic primary;
        logic secondary;
    } strobe_pair_type;

    typedef enum logic [1:0] {
        strobe_idle = 2'b00,
        strobe_wait_high = 2'b01,
        strobe_wait_low = 2'b10
    } strobe_state_type;

endpackage : lcd_bridge_pkg

// [rtl/lcd_write_stretch_bridge.sv]
`timescale 1ns/1ps
`default_nettype none

module lcd_write_stretch_bridge (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire lcd_bridge_pkg::bus_in_type bus_i,
    input wire logic display_register_select_i,
    input wire logic key_row_seven_n_i,
    input wire logic encoder_push_closed_i,
    input wire logic expansion_present_bit_n_i,
    output logic display_window_select_n_o,
    output logic expansion_select_n_o,
    output logic [7:0] display_data_o,
    output logic primary_display_enable_o,
    output logic secondary_display_enable_o,
    output logic primary_display_rw_o,
    output logic secondary_display_rw_o,
    output logic display_register_select_o,
    output logic key_column_seven_n_o,
    output logic expansion_data_bit_o,
    output logic expansion_addr_bit_o,
    output logic expansion_present_bit_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic window_sel_n_ff;
    logic nxt_window_sel_n;
    logic expansion_sel_n_ff;
    logic nxt_expansion_sel_n;
    logic [7:0] last_data_ff;
    logic [7:0] nxt_last_data;
    logic last_write_ff;
    logic nxt_last_write;
    logic last_a2_ff;
    logic nxt_last_a2;
    logic last_a1_ff;
    logic nxt_last_a1;
    logic [7:0] held_data_ff;
    logic [7:0] nxt_held_data;
    lcd_bridge_pkg::strobe_pair_type strobe_ff;
    lcd_bridge_pkg::strobe_pair_type nxt_strobe;
    lcd_bridge_pkg::strobe_state_type state_ff;
    lcd_bridge_pkg::strobe_state_type nxt_state;
    logic rs_ff;
    logic nxt_rs;
    logic key_col_n_ff;
    logic nxt_key_col_n;
    logic exp_data_ff;
    logic nxt_exp_data;
    logic exp_addr_ff;
    logic nxt_exp_addr;
    logic present_ff;
    logic nxt_present;

    logic upper_clear;
    logic window_hit;
    logic expansion_hit;
    logic window_release;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        upper_clear = (bus_i.addr[lcd_bridge_pkg::addr_top_hi_bit:lcd_bridge_pkg::addr_top_lo_bit]
                       == lcd_bridge_pkg::upper_select_clear);
        window_hit = 1'b0;
        expansion_hit = 1'b0;
        if (bus_i.phase && upper_clear
            && bus_i.addr >= lcd_bridge_pkg::display_window_first
            && bus_i.addr <= lcd_bridge_pkg::display_window_last) begin
            window_hit = 1'b1;
        end else if (bus_i.phase && upper_clear
            && bus_i.addr >= lcd_bridge_pkg::expansion_window_first
            && bus_i.addr <= lcd_bridge_pkg::expansion_window_last) begin
            expansion_hit = 1'b1;
        end
        nxt_window_sel_n = ~window_hit;
        nxt_expansion_sel_n = ~expansion_hit;
    end

    // ------------------------------------------------------------
    // write capture
    // ------------------------------------------------------------
    always_comb begin
        window_release = !window_sel_n_ff && nxt_window_sel_n;
        nxt_last_data = last_data_ff;
        nxt_last_write = last_write_ff;
        nxt_last_a2 = last_a2_ff;
        nxt_last_a1 = last_a1_ff;
        nxt_held_data = held_data_ff;
        if (window_hit) begin
            nxt_last_data = bus_i.data;
            nxt_last_write = !bus_i.read;
            nxt_last_a2 = bus_i.addr[lcd_bridge_pkg::addr_display_enable_bit];
            nxt_last_a1 = bus_i.addr[lcd_bridge_pkg::addr_display_choice_bit];
        end
        if (window_release && last_write_ff) begin
            nxt_held_data = last_data_ff;
        end
    end

    // ------------------------------------------------------------
    // strobe delay flops
    // ------------------------------------------------------------
    always_comb begin
        nxt_strobe = strobe_ff;
        nxt_state = state_ff;
        case (state_ff)
            lcd_bridge_pkg::strobe_idle: begin
                nxt_strobe = '0;
            end
            lcd_bridge_pkg::strobe_wait_high: begin
                if (bus_i.phase) begin
                    nxt_state = lcd_bridge_pkg::strobe_wait_low;
                end
            end
            lcd_bridge_pkg::strobe_wait_low: begin
                if (!bus_i.phase) begin
                    nxt_strobe = '0;
                    nxt_state = lcd_bridge_pkg::strobe_idle;
                end
            end
            default: begin
                nxt_strobe = '0;
                nxt_state = lcd_bridge_pkg::strobe_idle;
            end
        endcase
        if (window_release && last_write_ff && !last_a2_ff) begin
            nxt_strobe.primary = !last_a1_ff;
            nxt_strobe.secondary = last_a1_ff;
            nxt_state = lcd_bridge_pkg::strobe_wait_high;
        end
    end

    // ------------------------------------------------------------
    // side signals
    // ------------------------------------------------------------
    always_comb begin
        nxt_rs = display_register_select_i;
        nxt_key_col_n = key_row_seven_n_i | ~encoder_push_closed_i;
        nxt_exp_data = bus_i.data[lcd_bridge_pkg::data_expansion_bit];
        nxt_exp_addr = bus_i.addr[lcd_bridge_pkg::addr_expansion_bit];
        nxt_present = expansion_present_bit_n_i;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            window_sel_n_ff <= lcd_bridge_pkg::select_idle_level;
            expansion_sel_n_ff <= lcd_bridge_pkg::select_idle_level;
            last_data_ff <= lcd_bridge_pkg::held_data_reset;
            last_write_ff <= 1'b0;
            last_a2_ff <= 1'b0;
            last_a1_ff <= 1'b0;
            held_data_ff <= lcd_bridge_pkg::held_data_reset;
            strobe_ff <= '0;
            state_ff <= lcd_bridge_pkg::strobe_idle;
            rs_ff <= 1'b0;
            key_col_n_ff <= lcd_bridge_pkg::key_column_idle_level;
            exp_data_ff <= 1'b0;
            exp_addr_ff <= 1'b0;
            present_ff <= lcd_bridge_pkg::present_absent_level;
        end else begin
            window_sel_n_ff <= nxt_window_sel_n;
            expansion_sel_n_ff <= nxt_expansion_sel_n;
            last_data_ff <= nxt_last_data;
            last_write_ff <= nxt_last_write;
            last_a2_ff <= nxt_last_a2;
            last_a1_ff <= nxt_last_a1;
            held_data_ff <= nxt_held_data;
            strobe_ff <= nxt_strobe;
            state_ff <= nxt_state;
            rs_ff <= nxt_rs;
            key_col_n_ff <= nxt_key_col_n;
            exp_data_ff <= nxt_exp_data;
            exp_addr_ff <= nxt_exp_addr;
            present_ff <= nxt_present;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            primary_display_rw_o <= lcd_bridge_pkg::display_write_level;
            secondary_display_rw_o <= lcd_bridge_pkg::display_write_level;
        end else begin
            primary_display_rw_o <= lcd_bridge_pkg::display_write_level;
            secondary_display_rw_o <= lcd_bridge_pkg::display_write_level;
        end
    end

    assign display_window_select_n_o = window_sel_n_ff;
    assign expansion_select_n_o = expansion_sel_n_ff;
    assign display_data_o = held_data_ff;
    assign primary_display_enable_o = strobe_ff.primary;
    assign secondary_display_enable_o = strobe_ff.secondary;
    assign display_register_select_o = rs_ff;
    assign key_column_seven_n_o = key_col_n_ff;
    assign expansion_data_bit_o = exp_data_ff;
    assign expansion_addr_bit_o = exp_addr_ff;
    assign expansion_present_bit_o = present_ff;

endmodule : lcd_write_stretch_bridge

`default_nettype wire

// [verif/cpu_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------
// cpu bus master
// ------------
module cpu_bus_model (
    input wire logic clk_i,
    input wire logic fitted_i,
    output var lcd_bridge_pkg::bus_in_type bus_o,
    output logic rs_o,
    output logic present_n_o
);
    assign present_n_o = !fitted_i;
    initial begin
        bus_o = '0;
        rs_o = 1'b0;
    end
    // address half, then data half; one call per bus cycle
    task automatic cycle(input logic rd, input logic [15:0] a, input logic [7:0] d,
            input logic rs);
        @(posedge clk_i);
        bus_o <= '{phase: 1'b0, read: rd, addr: a, data: ~d};
        rs_o <= rs;
        repeat (2) @(posedge clk_i);
        bus_o.phase <= 1'b1;
        bus_o.data <= d;
        repeat (2) @(posedge clk_i);
    endtask : cycle
endmodule : cpu_bus_model
`default_nettype wire

// [verif/lcd_bridge_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_bridge_checker (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire lcd_bridge_pkg::bus_in_type bus_i,
    input wire logic display_register_select_i,
    input wire logic key_row_seven_n_i,
    input wire logic encoder_push_closed_i,
    input wire logic expansion_present_bit_n_i,
    input wire logic display_window_select_n_o,
    input wire logic expansion_select_n_o,
    input wire logic [7:0] display_data_o,
    input wire logic primary_display_enable_o,
    input wire logic secondary_display_enable_o,
    input wire logic primary_display_rw_o,
    input wire logic secondary_display_rw_o,
    input wire logic display_register_select_o,
    input wire logic key_column_seven_n_o,
    input wire logic expansion_data_bit_o,
    input wire logic expansion_addr_bit_o,
    input wire logic expansion_present_bit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ------------
    // checks
    // ------------
    wire hit = bus_i.phase && bus_i.addr[15:11] == 5'h03;
    wire xhit = bus_i.phase && bus_i.addr[15:11] == 5'h05;
    // select history and read flag of two cycles back
    logic sel_n_q;
    logic read_q1;
    logic read_q2;
    always_ff @(posedge clk_i) begin
        sel_n_q <= display_window_select_n_o;
        read_q1 <= bus_i.read;
        read_q2 <= read_q1;
    end
    wire cap = display_window_select_n_o && !sel_n_q && !read_q2;
    window_select_a: assert property (hit |=> !display_window_select_n_o)
        else $error("window select missed");
    window_idle_a: assert property (!hit |=> display_window_select_n_o)
        else $error("window select stray");
    expansion_sel_a: assert property (xhit |=> !expansion_select_n_o)
        else $error("expansion select missed");
    byte_capture_a: assert property (cap |-> display_data_o == $past(bus_i.data, 2))
        else $error("held byte wrong");
    byte_hold_a: assert property (!cap |-> $stable(display_data_o))
        else $error("held byte moved");
    primary_choice_a: assert property ($rose(primary_display_enable_o) |->
        cap && $past(bus_i.addr[2:1], 2) == 2'h0) else $error("primary strobe wrong");
    secondary_choice_a: assert property ($rose(secondary_display_enable_o) |->
        cap && $past(bus_i.addr[2:1], 2) == 2'h1) else $error("secondary strobe wrong");
    strobe_stretch_a: assert property ($rose(primary_display_enable_o) |->
        primary_display_enable_o [*4] ##[1:12] !primary_display_enable_o)
        else $error("strobe length wrong");
    write_level_a: assert property (!primary_display_rw_o && !secondary_display_rw_o)
        else $error("rw not write");
    side_pins_a: assert property (!$past(reset_i) |->
        key_column_seven_n_o == $past(key_row_seven_n_i | !encoder_push_closed_i)
        && expansion_present_bit_o == $past(expansion_present_bit_n_i))
        else $error("side pin wrong");
    pass_through_a: assert property (!$past(reset_i) |->
        display_register_select_o == $past(display_register_select_i)
        && expansion_data_bit_o == $past(bus_i.data[0])
        && expansion_addr_bit_o == $past(bus_i.addr[0]))
        else $error("pass through pin wrong");
    cover property ($rose(primary_display_enable_o));
    cover property ($rose(secondary_display_enable_o));
    cover property (!expansion_select_n_o);
endmodule : lcd_bridge_checker
bind lcd_write_stretch_bridge lcd_bridge_checker u_checker (.clk_i, .reset_i, .bus_i,
    .display_register_select_i,
    .key_row_seven_n_i, .encoder_push_closed_i, .expansion_present_bit_n_i,
    .display_window_select_n_o, .expansion_select_n_o, .display_data_o,
    .primary_display_enable_o, .secondary_display_enable_o, .primary_display_rw_o,
    .secondary_display_rw_o, .display_register_select_o, .key_column_seven_n_o,
    .expansion_data_bit_o, .expansion_addr_bit_o, .expansion_present_bit_o);
`default_nettype wire

// [verif/lcd_write_stretch_bridge_test.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_write_stretch_bridge_test;
    logic clk_i, reset_i, display_register_select_i, key_row_seven_n_i, fitted;
    logic encoder_push_closed_i, expansion_present_bit_n_i, primary_display_enable_o;
    lcd_bridge_pkg::bus_in_type bus_i;
    logic display_window_select_n_o, expansion_select_n_o, secondary_display_enable_o;
    logic primary_display_rw_o, secondary_display_rw_o, display_register_select_o;
    logic key_column_seven_n_o, expansion_data_bit_o, expansion_addr_bit_o;
    logic expansion_present_bit_o;
    logic [7:0] display_data_o;
    int n_mismatch = 0;
    int compares = 0;
    logic [15:0] sweep [6] = '{16'h17ff, 16'h1800, 16'h1fff, 16'h2000, 16'h2801, 16'h9800};
    logic [1:0] sel_exp [6] = '{2'h3, 2'h1, 2'h1, 2'h3, 2'h2, 2'h3};
    lcd_write_stretch_bridge dut (.clk_i, .reset_i, .bus_i, .display_register_select_i,
        .key_row_seven_n_i, .encoder_push_closed_i, .expansion_present_bit_n_i,
        .display_window_select_n_o, .expansion_select_n_o, .display_data_o,
        .primary_display_enable_o, .secondary_display_enable_o, .primary_display_rw_o,
        .secondary_display_rw_o, .display_register_select_o, .key_column_seven_n_o,
        .expansion_data_bit_o, .expansion_addr_bit_o, .expansion_present_bit_o);
    cpu_bus_model u_cpu (.clk_i, .fitted_i(fitted), .bus_o(bus_i),
        .rs_o(display_register_select_i), .present_n_o(expansion_present_bit_n_i));
    // ------------
    // tasks
    // ------------
    task automatic check(input logic [7:0] act, input logic [7:0] exp);
        compares++;
        if (act !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    // write, one spacer cycle, check strobes, one more cycle, strobes gone
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] en);
        u_cpu.cycle(1'b0, a, d, 1'b1);
        u_cpu.cycle(1'b1, 16'h0000, 8'h00, 1'b0);
        @(negedge clk_i);
        check(display_data_o, d);
        check({4'h0, primary_display_rw_o, secondary_display_rw_o, primary_display_enable_o,
            secondary_display_enable_o}, {6'h0, en});
        u_cpu.cycle(1'b1, 16'h0000, 8'h00, 1'b0);
        @(negedge clk_i);
        check({6'h0, primary_display_enable_o, secondary_display_enable_o}, 8'h00);
    endtask : wr
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end
    initial begin
        reset_i = 1'b1;
        key_row_seven_n_i = 1'b1;
        encoder_push_closed_i = 1'b0;
        fitted = 1'b0;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        check({6'h0, display_window_select_n_o, expansion_select_n_o}, 8'h03);
        check(display_data_o, 8'h00);
        wr(16'h1800, 8'ha5, 2'b10);
        wr(16'h1802, 8'h3c, 2'b01);
        wr(16'h1804, 8'h77, 2'b00);
        wr(16'h1ffa, 8'hc3, 2'b01);
        wr(16'h1ff9, 8'h5a, 2'b10);
        for (int i = 0; i < 6; i++) begin
            u_cpu.cycle(1'b1, sweep[i], sweep[i][7:0], sweep[i][1]);
            @(negedge clk_i);
            check({3'h0, display_window_select_n_o, expansion_select_n_o, expansion_addr_bit_o,
                expansion_data_bit_o, display_register_select_o},
                {3'h0, sel_exp[i], sweep[i][0], sweep[i][0], sweep[i][1]});
        end
        check(display_data_o, 8'h5a);
        @(posedge clk_i);
        key_row_seven_n_i <= 1'b0;
        encoder_push_closed_i <= 1'b1;
        fitted <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        check({6'h0, key_column_seven_n_o, expansion_present_bit_o}, 8'h00);
        @(posedge clk_i);
        encoder_push_closed_i <= 1'b0;
        fitted <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        check({6'h0, key_column_seven_n_o, expansion_present_bit_o}, 8'h03);
        finish_test();
    end
endmodule : lcd_write_stretch_bridge_test
`default_nettype wire
